// ---- test/ppr_pad_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module ppr_pad_model (
  // Clock
  input wire logic                         clock_in,
  // Device side
  input wire logic [ppr_pkg::NUM_PADS-1:0] pad_out_in,
  input wire logic [ppr_pkg::NUM_PADS-1:0] pad_oe_n_in,
  // Pad levels
  output var logic [ppr_pkg::NUM_PADS-1:0] pad_level_out
);
  import ppr_pkg::*;
  // No pulls: an undriven pad shows a pattern that moves every cycle
  logic [NUM_PADS-1:0] far_reg = 48'h5a3c96e10f2d;
  always_ff @(posedge clock_in) begin
    far_reg <= {far_reg[46:0], ~far_reg[47]};
  end
  always_comb begin
    pad_level_out = (pad_out_in & ~pad_oe_n_in) | (far_reg & pad_oe_n_in);
  end
endmodule : ppr_pad_model

`default_nettype wire

// ---- test/ppr_route_props.sv ----
`timescale 1ns/100ps
`default_nettype none

module ppr_route_props (
  // Clock and reset
  input wire logic                         clock_in,
  input wire logic                         rstn_in,
  // Bus
  input wire logic [ppr_pkg::ADDR_W-1:0]   avs_address_in,
  input wire logic                         avs_read_in,
  input wire logic                         avs_write_in,
  input wire logic [ppr_pkg::DATA_W-1:0]   avs_readdata_out,
  input wire logic                         avs_waitrequest_out,
  // Pads
  input wire logic [ppr_pkg::NUM_PADS-1:0] pad_in,
  input wire logic [ppr_pkg::NUM_PADS-1:0] pad_oe_n_out,
  input wire logic [3*ppr_pkg::NUM_LUT-1:0] logic_table_in_out
);
  import ppr_pkg::*;
  // ****
  // Helpers
  // ****
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic rdack;
  logic unmap;
  assign rdack = avs_read_in && !avs_waitrequest_out;
  assign unmap = avs_address_in[4] || (avs_address_in[1:0] != 2'h0);
  sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence s_ack; !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
  // ****
  // Properties
  // ****
  property p_ack; s_req |=> s_ack; endproperty
  property p_idle; !(avs_read_in || avs_write_in) |=> avs_waitrequest_out; endproperty
  property p_unmap; rdack && unmap |-> avs_readdata_out == 32'h0; endproperty
  property p_upper; avs_readdata_out[31:8] == 24'h0; endproperty
  property p_evt; rdack && avs_address_in == ADDR_EVT_ROUTE |-> avs_readdata_out[7:6] == 2'h0;
  endproperty
  property p_lut; rdack && avs_address_in == ADDR_LUT_ROUTE |-> avs_readdata_out[7:5] == 3'h0;
  endproperty
  property p_serb; rdack && avs_address_in == ADDR_SER_ROUTE_B |-> avs_readdata_out[7:2] == 6'h0;
  endproperty
  property p_rst_pads; $rose(rstn_in) |-> pad_oe_n_out == {NUM_PADS{1'b1}}; endproperty
  // Pins that no routing choice ever reaches
  property p_free; pad_oe_n_out[15:14] == 2'h3 && pad_oe_n_out[29:28] == 2'h3
    && pad_oe_n_out[47:46] == 2'h3; endproperty
  property p_logic_table2_route; $past(rstn_in) |-> logic_table_in_out[8:6] == $past(pad_in[26:24]); endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_evt: assert property (p_evt) else $error("event route spare bits set");
  a_lut: assert property (p_lut) else $error("table route spare bits set");
  a_serb: assert property (p_serb) else $error("serial route b spare bits set");
  a_rst_pads: assert property (p_rst_pads) else $error("pad driven in reset");
  a_free: assert property (p_free) else $error("unused pad driven");
  a_logic_table2_route: assert property (p_logic_table2_route) else $error("table 2 inputs wrong");
endmodule : ppr_route_props

bind ppr_route ppr_route_props chk_u (
  .clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .pad_in(pad_in), .pad_oe_n_out(pad_oe_n_out),
  .logic_table_in_out(logic_table_in_out));

`default_nettype wire

// ---- test/ppr_route_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; $display("Error %s exp %h got %h", nm, ex, got); end end

module ppr_route_tb;
  import ppr_pkg::*;
  // ****
  // Signals
  // ****
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wreq, chk = 1'b0;
  logic [4:0]  adr = '0, lo = '0, tx = '0, ckv = '0, ckd = '0, dir = '0, rx, ck, er, ek;
  logic [31:0] wd = '0, rdat, got;
  logic [3:0]  be = '0;
  logic [5:0]  ev = '0;
  logic [14:0] ti, et;
  logic [47:0] pi, po, oe, eo, ep;
  logic [7:0]  sh [4];
  int          n_errors = 0, n_checks = 0, seed = 32'h45d51317, pseed = 32'h1b2e3d4c;
  localparam int         LP [5] = '{0, 2, 3, 5, 1};
  localparam int         SP [5] = '{0, 2, 5, 1, 4};
  localparam logic [7:0] MSK [4] = '{8'h3f, 8'h1f, 8'hff, 8'h03};

  ppr_route dut_u (.clock_in(clk), .rstn_in(rstn), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .event_out_in(ev), .logic_table_out_in(lo),
    .logic_table_in_out(ti), .serial_txd_in(tx), .serial_rxd_out(rx),
    .serial_clock_line_in(ckv), .serial_clock_line_drive_in(ckd), .serial_clock_line_out(ck),
    .serial_direction_line_in(dir), .pad_in(pi), .pad_out(po), .pad_oe_n_out(oe));
  ppr_pad_model pad_u (.clock_in(clk), .pad_out_in(po), .pad_oe_n_in(oe), .pad_level_out(pi));

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin : pins
    logic [31:0] r;
    r = $random(pseed);
    {ev, lo, tx, ckv, ckd, dir} <= r[30:0];
  end
  // ****
  // Expected pad picture; serial beats table beats event
  // ****
  function automatic void sd(inout logic [47:0] o, v, input int i, input logic b);
    o[i] = 1'b0;
    v[i] = b;
  endfunction : sd
  function automatic void expect_pads();
    int p, b, m;
    eo = '1; ep = '0; et = '0; er = '1; ek = '0;
    for (int e = 0; e < 6; e++) begin
      p = 8 * e;
      if (!sh[0][e]) sd(eo, ep, p + 2, ev[e]);
      else if (e == 0 || e == 2 || e == 3) sd(eo, ep, p + 7, ev[e]);
    end
    for (int t = 0; t < 5; t++) begin
      p = 8 * LP[t];
      if (!sh[1][t] || t < 3) begin
        sd(eo, ep, p + (sh[1][t] ? 6 : 3), lo[t]);
        et[3*t+:3] = pi[p+:3];
      end
    end
    for (int s = 0; s < 5; s++) begin
      p = 8 * SP[s];
      m = (s < 4) ? sh[2][2*s+:2] : sh[3][1:0];
      if (m < 2) begin
        b = p + 4 * m;
        sd(eo, ep, b, tx[s]);
        er[s] = pi[b+1];
        if (m == 0 || s < 2 || s == 4) begin
          if (ckd[s]) sd(eo, ep, b + 2, ckv[s]);
          else eo[b+2] = 1'b1;
          ek[s] = pi[b+2];
          sd(eo, ep, b + 3, dir[s]);
        end
      end
    end
  endfunction : expect_pads
  // Model at the falling edge, where inputs and pads are settled
  always @(negedge clk) expect_pads();
  always @(posedge clk) if (chk) begin
    #1;
    `CHK("pad_oe_n", eo, oe)
    `CHK("pad_out", ep & ~eo, po & ~eo)
    `CHK("table_in", et, ti)
    `CHK("rxd", er, rx)
    `CHK("clock_line", ek, ck)
  end
  // ****
  // Bus and sequencing
  // ****
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] e);
    int n;
    @(posedge clk);
    adr <= a; wr <= w; rd <= !w; wd <= {24'ha5a5a5, d}; be <= e;
    n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 20);
    got = rdat;
    rd <= 1'b0; wr <= 1'b0;
    if (n >= 20) begin n_errors++; $display("Error waitrequest exp 0 got 1"); end
    if (w && e[0] && !a[4] && a[1:0] == 2'h0) sh[a[3:2]] = d & MSK[a[3:2]];
  endtask : bus
  task automatic rchk(input logic [4:0] a);
    bus(1'b0, a, 8'h00, 4'hf);
    `CHK("readdata", ((a[4] || a[1:0] != 2'h0) ? 32'h0 : {24'h0, sh[a[3:2]]}), got)
  endtask : rchk
  task automatic rst();
    chk = 1'b0;
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("pad_oe_n_reset", {NUM_PADS{1'b1}}, oe)
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) sh[i] = 8'h00;
    repeat (2) @(posedge clk);
    chk = 1'b1;
  endtask : rst
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    n_errors++;
    $display("Error watchdog exp done got timeout");
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic [4:0]  a;
    rst();
    for (int j = 0; j < 6; j++) rchk(j == 4 ? 5'h10 : (j == 5 ? 5'h05 : 5'(4 * j)));
    $display("test reset_values done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADDR_SER_ROUTE_A, {4{2'(m)}}, 4'h1);
      bus(1'b1, ADDR_SER_ROUTE_B, 8'(m), 4'h1);
      bus(1'b1, ADDR_EVT_ROUTE, m[0] ? 8'hff : 8'h00, 4'h1);
      bus(1'b1, ADDR_LUT_ROUTE, m[1] ? 8'hff : 8'h00, 4'h1);
      repeat (4) @(posedge clk);
      for (int j = 0; j < 4; j++) rchk(5'(4 * j));
    end
    $display("test modes done");
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      a = (r[7:5] != 3'h0) ? {1'b0, r[9:8], 2'h0} : r[4:0];
      bus(1'b1, a, r[23:16], r[13:10]);
      rchk(a);
    end
    $display("test random done");
    bus(1'b1, ADDR_SER_ROUTE_A, 8'h5a, 4'hf);
    rst();
    for (int j = 0; j < 4; j++) rchk(5'(4 * j));
    $display("test mid_reset done");
    summarize();
  end
endmodule : ppr_route_tb

`default_nettype wire

// ---- verilog/ppr_pkg.sv ----
`default_nettype none

package ppr_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 32;
  localparam int          BE_W           = 4;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [2:0]  IDX_EVT_ROUTE  = 3'h0;
  localparam logic [2:0]  IDX_LUT_ROUTE  = 3'h1;
  localparam logic [2:0]  IDX_SER_ROUTE_A = 3'h2;
  localparam logic [2:0]  IDX_SER_ROUTE_B = 3'h3;
  localparam logic [4:0]  ADDR_EVT_ROUTE  = 5'(4 * IDX_EVT_ROUTE);
  localparam logic [4:0]  ADDR_LUT_ROUTE  = 5'(4 * IDX_LUT_ROUTE);
  localparam logic [4:0]  ADDR_SER_ROUTE_A = 5'(4 * IDX_SER_ROUTE_A);
  localparam logic [4:0]  ADDR_SER_ROUTE_B = 5'(4 * IDX_SER_ROUTE_B);

  // ****************************************
  // Reset values and writable bit masks
  // ****************************************
  localparam logic [7:0]  ROUTE_RESET    = 8'h00;
  localparam logic [7:0]  MASK_EVT_ROUTE = 8'h3f;
  localparam logic [7:0]  MASK_LUT_ROUTE = 8'h1f;
  localparam logic [7:0]  MASK_SER_ROUTE_A = 8'hff;
  localparam logic [7:0]  MASK_SER_ROUTE_B = 8'h03;

  // ****************************************
  // Pad numbering: port index times eight plus pin
  // ****************************************
  localparam int          NUM_PORTS      = 6;
  localparam int          PINS_PER_PORT  = 8;
  localparam int          NUM_PADS       = NUM_PORTS * PINS_PER_PORT;
  localparam logic [2:0]  PORT_A         = 3'h0;
  localparam logic [2:0]  PORT_B         = 3'h1;
  localparam logic [2:0]  PORT_C         = 3'h2;
  localparam logic [2:0]  PORT_D         = 3'h3;
  localparam logic [2:0]  PORT_E         = 3'h4;
  localparam logic [2:0]  PORT_F         = 3'h5;

  // ****************************************
  // Event outputs: channel n sits on port n
  // ****************************************
  localparam int          NUM_EVT        = 6;
  localparam logic [2:0]  EVT_DEF_PIN    = 3'h2;
  localparam logic [2:0]  EVT_ALT_PIN    = 3'h7;
  localparam logic [5:0]  EVT_ALT_HAS_PIN = 6'h0d;

  // ****************************************
  // Logic tables: ports per table, table 4 first
  // ****************************************
  localparam int          NUM_LUT        = 5;
  localparam logic [14:0] LUT_PORT       = {PORT_B, PORT_F, PORT_D, PORT_C, PORT_A};
  localparam logic [2:0]  LUT_OUT_DEF_PIN = 3'h3;
  localparam logic [2:0]  LUT_OUT_ALT_PIN = 3'h6;
  localparam logic [2:0]  LUT_IN0_PIN    = 3'h0;
  localparam logic [4:0]  LUT_ALT_HAS_PIN = 5'h07;

  // ****************************************
  // Serial instances: ports per instance, instance 4 first
  // ****************************************
  localparam int          NUM_SER        = 5;
  localparam logic [14:0] SER_PORT       = {PORT_E, PORT_B, PORT_F, PORT_C, PORT_A};
  localparam logic [2:0]  SER_DEF_BASE   = 3'h0;
  localparam logic [2:0]  SER_ALT_BASE   = 3'h4;
  localparam logic [4:0]  SER_ALT_FULL   = 5'h13;

  typedef enum logic [1:0] {
    SER_DEFAULT,
    SER_ALTERNATIVE,
    SER_RESERVED,
    SER_NONE
  } ppr_serial_mode_t;

endpackage : ppr_pkg

`default_nettype wire

// ---- verilog/ppr_route.sv ----
// Contract
// RULE1 - Event channel F drives PF2 when its bit is 0; alternative has no pin.
// RULE2 - Event channel E drives PE2 when its bit is 0; alternative has no pin.
// RULE3 - Event channel D drives PD2 when bit is 0, PD7 when 1.
// RULE4 - Event channel C drives PC2 when bit is 0, PC7 when 1.
// RULE5 - Event channel B drives PB2 when its bit is 0; alternative has no pin.
// RULE6 - Event channel A drives PA2 when bit is 0, PA7 when 1.
// RULE7 - Table 4 default: output PB3, inputs PB0-PB2; alternative leaves output unrouted.
// RULE8 - Table 3 default: output PF3, inputs PF0-PF2; alternative places nothing.
// RULE9 - Table 2 output PD3 or PD6; inputs always PD0-PD2.
// RULE10 - Table 1 output PC3 or PC6; inputs always PC0-PC2.
// RULE11 - Table 0 output PA3 or PA6; inputs always PA0-PA2.
// RULE12 - Serial 3 field 7:6: default PB0-PB3; alternative only transmit/receive on PB4, PB5.
// RULE13 - Serial 2 field 5:4: default PF0-PF3; alternative only transmit/receive on PF4, PF5.
// RULE14 - Serial 1 field 3:2: default PC0-PC3; alternative PC4-PC7.
// RULE15 - Serial 0 field 1:0 of first register: default PA0-PA3; alternative PA4-PA7.
// RULE16 - Serial 4 field 1:0 of second register: default PE0-PE3; alternative PE4-PE7.
// RULE17 - Serial field value 3 disconnects the instance; value 2 reserved.
// RULE18 - All routing registers reset to zero, default positions.
// RULE19 - Undefined bits read zero and ignore writes; defined fields read/write.
// RULE20 - A signal with no pin in the chosen setting touches no pad.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module ppr_route (
  // Clock and reset
  input  wire logic                          clock_in,
  input  wire logic                          rstn_in,
  // Avalon-MM slave
  input  wire logic [ppr_pkg::ADDR_W-1:0]    avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [ppr_pkg::DATA_W-1:0]    avs_writedata_in,
  input  wire logic [ppr_pkg::BE_W-1:0]      avs_byteenable_in,
  output var  logic [ppr_pkg::DATA_W-1:0]    avs_readdata_out,
  output var  logic                          avs_waitrequest_out,
  // Peripheral side
  input  wire logic [ppr_pkg::NUM_EVT-1:0]   event_out_in,
  input  wire logic [ppr_pkg::NUM_LUT-1:0]   logic_table_out_in,
  output var  logic [3*ppr_pkg::NUM_LUT-1:0] logic_table_in_out,
  input  wire logic [ppr_pkg::NUM_SER-1:0]   serial_txd_in,
  output var  logic [ppr_pkg::NUM_SER-1:0]   serial_rxd_out,
  input  wire logic [ppr_pkg::NUM_SER-1:0]   serial_clock_line_in,
  input  wire logic [ppr_pkg::NUM_SER-1:0]   serial_clock_line_drive_in,
  output var  logic [ppr_pkg::NUM_SER-1:0]   serial_clock_line_out,
  input  wire logic [ppr_pkg::NUM_SER-1:0]   serial_direction_line_in,
  // Pad side
  input  wire logic [ppr_pkg::NUM_PADS-1:0]  pad_in,
  output var  logic [ppr_pkg::NUM_PADS-1:0]  pad_out,
  output var  logic [ppr_pkg::NUM_PADS-1:0]  pad_oe_n_out
);
  import ppr_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [5:0] pad_idx(input logic [2:0] port, input logic [2:0] pin);
    return {port, pin};
  endfunction : pad_idx

  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic [7:0] mask);
    return (new_val & mask) | (old_val & ~mask);
  endfunction : merge_byte

  // ****************************************
  // Routing registers
  // ****************************************
  logic [7:0]                 event_output_pin_route_reg;
  logic [7:0]                 logic_table_pin_route_reg;
  logic [7:0]                 serial_pin_route_a_reg;
  logic [7:0]                 serial_pin_route_b_reg;
  logic                       wait_reg;
  logic [DATA_W-1:0]          readdata_reg;
  logic                       accept;
  logic                       wr_hit;
  logic [2:0]                 acc_idx;
  logic                       acc_mapped;
  logic [7:0]                 read_byte;

  assign acc_idx    = {1'b0, avs_address_in[3:2]};
  // Upper half of the window and unaligned byte addresses are unmapped
  assign acc_mapped = (avs_address_in[4] == 1'b0) && (avs_address_in[1:0] == 2'h0);
  assign accept     = (avs_read_in || avs_write_in) && !wait_reg;
  assign wr_hit     = accept && avs_write_in && acc_mapped && avs_byteenable_in[0];

  // Every request waits exactly one cycle, so read data come from a flop
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wait_reg <= 1'b1;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (avs_read_in || avs_write_in) begin
      wait_reg <= 1'b0;
    end
  end

  always_comb begin
    read_byte = 8'h00;
    unique case (acc_idx)
      IDX_EVT_ROUTE:   read_byte = event_output_pin_route_reg; // RULE19
      IDX_LUT_ROUTE:   read_byte = logic_table_pin_route_reg; // RULE19
      IDX_SER_ROUTE_A: read_byte = serial_pin_route_a_reg; // RULE19
      IDX_SER_ROUTE_B: read_byte = serial_pin_route_b_reg; // RULE19
      default:         read_byte = 8'h00;
    endcase
    if (!acc_mapped) begin
      read_byte = 8'h00;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && wait_reg) begin
      readdata_reg <= {24'h00_0000, read_byte};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      event_output_pin_route_reg <= ROUTE_RESET; // RULE18
      logic_table_pin_route_reg  <= ROUTE_RESET; // RULE18
      serial_pin_route_a_reg     <= ROUTE_RESET; // RULE18
      serial_pin_route_b_reg     <= ROUTE_RESET; // RULE18
    end else if (wr_hit) begin
      unique case (acc_idx)
        IDX_EVT_ROUTE: begin
          event_output_pin_route_reg <= merge_byte(8'h00, avs_writedata_in[7:0],
                                                   MASK_EVT_ROUTE); // RULE19
        end
        IDX_LUT_ROUTE: begin
          logic_table_pin_route_reg <= merge_byte(8'h00, avs_writedata_in[7:0],
                                                  MASK_LUT_ROUTE); // RULE19
        end
        IDX_SER_ROUTE_A: begin
          serial_pin_route_a_reg <= merge_byte(8'h00, avs_writedata_in[7:0],
                                               MASK_SER_ROUTE_A); // RULE19
        end
        IDX_SER_ROUTE_B: begin
          serial_pin_route_b_reg <= merge_byte(8'h00, avs_writedata_in[7:0],
                                               MASK_SER_ROUTE_B); // RULE19
        end
        default: begin
        end
      endcase
    end
  end

  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out    = readdata_reg;

  // ****************************************
  // Pad routing
  // ****************************************
  // Later writers win on a shared pad: serial over table over event
  logic [NUM_PADS-1:0]        pad_val_next;
  logic [NUM_PADS-1:0]        pad_drv_next;
  logic [3*NUM_LUT-1:0]       lut_in_next;
  logic [NUM_SER-1:0]         rxd_next;
  logic [NUM_SER-1:0]         clock_line_next;
  logic [NUM_PADS-1:0]        pad_val_reg;
  logic [NUM_PADS-1:0]        pad_oe_n_reg;
  logic [3*NUM_LUT-1:0]       lut_in_reg;
  logic [NUM_SER-1:0]         rxd_reg;
  logic [NUM_SER-1:0]         clock_line_reg;

  always_comb begin
    logic [2:0]             port;
    logic [2:0]             base;
    logic [1:0]             field;
    ppr_serial_mode_t       mode;
    port         = 3'h0;
    base         = 3'h0;
    field        = 2'h0;
    mode         = SER_DEFAULT;
    pad_val_next = '0;
    pad_drv_next = '0;
    lut_in_next  = '0;
    // Receive idles high so an unrouted receiver sees no start bit
    rxd_next     = '1;
    clock_line_next = '0;
    for (int ch = 0; ch < NUM_EVT; ch++) begin
      port = 3'(ch);
      if (!event_output_pin_route_reg[ch]) begin
        pad_drv_next[pad_idx(port, EVT_DEF_PIN)] = 1'b1; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
        pad_val_next[pad_idx(port, EVT_DEF_PIN)] = event_out_in[ch];
      end else if (EVT_ALT_HAS_PIN[ch]) begin
        pad_drv_next[pad_idx(port, EVT_ALT_PIN)] = 1'b1; // RULE3 RULE4 RULE6
        pad_val_next[pad_idx(port, EVT_ALT_PIN)] = event_out_in[ch];
      end // RULE20
    end
    for (int t = 0; t < NUM_LUT; t++) begin
      port = LUT_PORT[3*t +: 3];
      if (!logic_table_pin_route_reg[t]) begin
        pad_drv_next[pad_idx(port, LUT_OUT_DEF_PIN)] = 1'b1; // RULE7 RULE8 RULE9 RULE10 RULE11
        pad_val_next[pad_idx(port, LUT_OUT_DEF_PIN)] = logic_table_out_in[t];
        lut_in_next[3*t +: 3] = pad_in[pad_idx(port, LUT_IN0_PIN) +: 3]; // RULE7 RULE8
      end else if (LUT_ALT_HAS_PIN[t]) begin
        pad_drv_next[pad_idx(port, LUT_OUT_ALT_PIN)] = 1'b1; // RULE9 RULE10 RULE11
        pad_val_next[pad_idx(port, LUT_OUT_ALT_PIN)] = logic_table_out_in[t];
        lut_in_next[3*t +: 3] = pad_in[pad_idx(port, LUT_IN0_PIN) +: 3]; // RULE9 RULE10 RULE11
      end // RULE20
    end
    for (int n = 0; n < NUM_SER; n++) begin
      port  = SER_PORT[3*n +: 3];
      // Index folded so the unused arm never selects past the register
      field = (n < 4) ? serial_pin_route_a_reg[2*(n % 4) +: 2]
                      : serial_pin_route_b_reg[1:0]; // RULE15 RULE16
      mode  = ppr_serial_mode_t'(field);
      base  = (mode == SER_ALTERNATIVE) ? SER_ALT_BASE : SER_DEF_BASE;
      // Reserved code is held off the pads like the disconnect code
      if ((mode == SER_DEFAULT) || (mode == SER_ALTERNATIVE)) begin // RULE17
        pad_drv_next[pad_idx(port, base)]        = 1'b1; // RULE12 RULE13 RULE14 RULE15 RULE16
        pad_val_next[pad_idx(port, base)]        = serial_txd_in[n];
        rxd_next[n] = pad_in[pad_idx(port, base + 3'h1)]; // RULE12 RULE13 RULE14 RULE15 RULE16
        if ((mode == SER_DEFAULT) || SER_ALT_FULL[n]) begin // RULE12 RULE13 RULE20
          clock_line_next[n] = pad_in[pad_idx(port, base + 3'h2)]; // RULE14 RULE15 RULE16
          pad_drv_next[pad_idx(port, base + 3'h2)] = serial_clock_line_drive_in[n];
          pad_val_next[pad_idx(port, base + 3'h2)] = serial_clock_line_in[n];
          pad_drv_next[pad_idx(port, base + 3'h3)] = 1'b1; // RULE14 RULE15 RULE16
          pad_val_next[pad_idx(port, base + 3'h3)] = serial_direction_line_in[n];
        end
      end
    end
  end

  // Pads and receive lines are registered so every output leaves a flop
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pad_val_reg  <= '0;
      pad_oe_n_reg <= '1;
    end else begin
      pad_val_reg  <= pad_val_next;
      pad_oe_n_reg <= ~pad_drv_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      lut_in_reg     <= '0;
      rxd_reg        <= '1;
      clock_line_reg <= '0;
    end else begin
      lut_in_reg     <= lut_in_next;
      rxd_reg        <= rxd_next;
      clock_line_reg <= clock_line_next;
    end
  end

  assign pad_out               = pad_val_reg;
  assign pad_oe_n_out          = pad_oe_n_reg;
  assign logic_table_in_out    = lut_in_reg;
  assign serial_rxd_out        = rxd_reg;
  assign serial_clock_line_out = clock_line_reg;

endmodule : ppr_route

`default_nettype wire
